// >>> cau_pkg.sv
`default_nettype none
package cau_pkg;
    // Local register map, byte addresses on the local register port
    localparam logic [9:0]  OFS_IND_ADDR    = 10'h000;
    localparam logic [9:0]  OFS_IND_CBE     = 10'h004;
    localparam logic [9:0]  OFS_IND_WDATA   = 10'h008;
    localparam logic [9:0]  OFS_IND_RDATA   = 10'h00C;
    localparam logic [9:0]  OFS_CTRL        = 10'h010;
    // Configuration header window: addresses 0x100..0x1FC
    localparam logic [1:0]  CFG_WINDOW      = 2'h1;

    // Control/status register fields
    localparam int          CSR_HOST_BIT    = 0;
    localparam int          CSR_ARB_BIT     = 1;
    localparam int          CSR_IC_BIT      = 15;
    localparam int          CSR_BUSY_RD_BIT = 16;
    localparam int          CSR_BUSY_WR_BIT = 17;

    // Indirect command register fields
    localparam int          CBE_CMD_LSB     = 0;
    localparam int          CBE_BE_LSB      = 4;
    localparam logic [3:0]  CMD_CFG_READ    = 4'hA;
    localparam logic [3:0]  CMD_CFG_WRITE   = 4'hB;

    // Configuration header register indices
    localparam logic [5:0]  CFG_IDX_ID      = 6'h00;
    localparam logic [5:0]  CFG_IDX_CMD     = 6'h01;
    localparam logic [5:0]  CFG_IDX_BAR0    = 6'h04;
    localparam logic [5:0]  CFG_IDX_SUBSYS  = 6'h0B;
    localparam logic [5:0]  CFG_IDX_INTLINE = 6'h0F;
    localparam logic [1:0]  TYPE0_BITS      = 2'h0;
    localparam logic [2:0]  FUNC_ZERO       = 3'h0;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;

    // Bus edges without a device select before a master abort
    localparam logic [2:0]  ABORT_EDGES     = 3'h5;
    localparam logic [31:0] ABORT_DATA      = 32'hFFFFFFFF;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_T_WAIT = 8'h02,
        ST_T_DATA = 8'h04,
        ST_T_STOP = 8'h08,
        ST_T_TURN = 8'h10,
        ST_M_ADDR = 8'h20,
        ST_M_DATA = 8'h40,
        ST_M_TURN = 8'h80
    } cau_fsm_t;

    typedef struct packed {
        logic        clk;
        logic        frame_n;
        logic        irdy_n;
        logic        trdy_n;
        logic        devsel_n;
        logic        stop_n;
        logic        idsel;
        logic [31:0] ad;
        logic [3:0]  cbe_n;
    } cau_pin_in_t;

    typedef struct packed {
        logic [31:0] ad;
        logic        ad_oe;
        logic [3:0]  cbe_n;
        logic        cbe_oe;
        logic        frame_n;
        logic        frame_oe;
        logic        irdy_n;
        logic        irdy_oe;
        logic        trdy_n;
        logic        trdy_oe;
        logic        devsel_n;
        logic        devsel_oe;
        logic        stop_n;
        logic        stop_oe;
    } cau_pin_out_t;

    localparam cau_pin_out_t PIN_OUT_IDLE = '{
        ad: 32'h00000000, ad_oe: 1'b0, cbe_n: 4'hF, cbe_oe: 1'b0,
        frame_n: 1'b1, frame_oe: 1'b0, irdy_n: 1'b1, irdy_oe: 1'b0,
        trdy_n: 1'b1, trdy_oe: 1'b0, devsel_n: 1'b1, devsel_oe: 1'b0,
        stop_n: 1'b1, stop_oe: 1'b0};

    typedef struct packed {
        logic        req;
        logic        we;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } cau_lreq_t;

    typedef struct packed {
        cau_pin_in_t  s1;
        cau_pin_in_t  s2;
        logic         clk_q;
        cau_fsm_t     st;
        logic [31:0]  np_addr;
        logic [31:0]  np_cbe;
        logic [31:0]  np_wdata;
        logic [31:0]  np_rdata;
        logic         is_write;
        logic         busy_rd;
        logic         busy_wr;
        logic         m_ok;
        logic [2:0]   abort_cnt;
        logic         ic;
        logic         arb_en;
        logic         host_mode;
        logic [15:0]  cfg_cmd;
        logic [31:0]  bar0;
        logic [31:0]  ssid;
        logic [7:0]   int_line;
        logic [5:0]   t_idx;
        logic         t_write;
        cau_pin_out_t po;
        logic [31:0]  l_rdata;
        logic         l_ack;
    } cau_state_t;
endpackage : cau_pkg
`default_nettype wire

// >>> cau_config_access_unit.sv
`timescale 1ns/100ps
`default_nettype none
module cau_config_access_unit #(
    parameter logic [15:0] VENDOR_ID = 16'h1AB0, // Arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h0C01, // Arbitrary value
    parameter logic [31:0] BAR0_MASK = 32'hFF000000
) (
    input  wire logic                  MCLK,
    input  wire logic                  RESET_N,
    input  wire cau_pkg::cau_pin_in_t  PCI_IN,
    output var  cau_pkg::cau_pin_out_t PCI_OUT,
    input  wire cau_pkg::cau_lreq_t    LREQ,
    output logic [31:0]                LRDATA,
    output logic                       LACK,
    output logic                       LRETRY,
    output logic                       HOST_MODE,
    output logic                       ARB_EN,
    output logic                       INIT_COMPLETE
);
    import cau_pkg::*;

    cau_state_t s;
    cau_state_t next_s;
    logic       pe;
    logic       lreq_take;
    logic       cfg_claim;
    logic       cfg_hit_local;
    logic [31:0] t_merged;

    // Pins read as an idle bus until the synchroniser fills, so leaving
    // reset cannot fake a bus clock edge or a frame
    localparam cau_pin_in_t PIN_IN_IDLE = '{
        clk: 1'b1, frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1,
        devsel_n: 1'b1, stop_n: 1'b1, idsel: 1'b0, ad: 32'h00000000,
        cbe_n: 4'hF};

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  be_n
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (!be_n[i])
                res[i*8 +: 8] = new_word[i*8 +: 8];
        end
        return res;
    endfunction : be_merge

    function automatic logic [31:0] cfg_read(
        input logic [5:0] idx,
        input cau_state_t st
    );
        case (idx)
            CFG_IDX_ID:      return {DEVICE_ID, VENDOR_ID};
            CFG_IDX_CMD:     return {STATUS_RESET, st.cfg_cmd};
            CFG_IDX_BAR0:    return st.bar0;
            CFG_IDX_SUBSYS:  return st.ssid;
            CFG_IDX_INTLINE: return {24'h000000, st.int_line};
            default:         return 32'h00000000;
        endcase
    endfunction : cfg_read

    // Rising edge of the synchronised bus clock; bus logic steps on it
    assign pe = s.s2.clk & ~s.clk_q;

    // Indirect registers must stay put while a cycle uses them
    assign LRETRY = LREQ.req
                  & (LREQ.we ? (s.busy_rd | s.busy_wr) : s.busy_rd);
    assign lreq_take = LREQ.req & ~LRETRY;
    assign cfg_hit_local = (LREQ.addr[9:8] == CFG_WINDOW);

    // Bus writes merge by byte enables into the addressed register
    assign t_merged = be_merge(cfg_read(s.t_idx, s), s.s2.ad, s.s2.cbe_n);

    assign cfg_claim = s.s2.idsel
                     && (s.s2.cbe_n[3:1] == CMD_CFG_READ[3:1])
                     && (s.s2.ad[1:0] == TYPE0_BITS)
                     && (s.s2.ad[10:8] == FUNC_ZERO)
                     && s.ic;

    always_comb
    begin
        next_s = s;
        next_s.s1 = PCI_IN;
        next_s.s2 = s.s1;
        next_s.clk_q = s.s2.clk;
        next_s.l_ack = 1'b0;

        if (lreq_take)
        begin
            next_s.l_ack = 1'b1;
            if (LREQ.we)
            begin
                case (LREQ.addr)
                    OFS_IND_ADDR:  next_s.np_addr = LREQ.wdata;
                    OFS_IND_CBE:
                    begin
                        next_s.np_cbe = LREQ.wdata;
                        // Even command codes are reads, the write itself
                        // starts them
                        if (!LREQ.wdata[CBE_CMD_LSB])
                        begin
                            next_s.busy_rd = 1'b1;
                            next_s.is_write = 1'b0;
                        end
                    end
                    OFS_IND_WDATA:
                    begin
                        next_s.np_wdata = LREQ.wdata;
                        next_s.busy_wr = 1'b1;
                        next_s.is_write = 1'b1;
                    end
                    OFS_CTRL:
                    begin
                        next_s.host_mode = LREQ.wdata[CSR_HOST_BIT];
                        next_s.arb_en = LREQ.wdata[CSR_ARB_BIT];
                        next_s.ic = LREQ.wdata[CSR_IC_BIT];
                    end
                    default:
                    begin
                        // Header belongs to local software until ready
                        if (cfg_hit_local && !s.ic)
                        begin
                            case (LREQ.addr[7:2])
                                CFG_IDX_CMD:
                                    next_s.cfg_cmd = LREQ.wdata[15:0];
                                CFG_IDX_BAR0:
                                    next_s.bar0 = LREQ.wdata & BAR0_MASK;
                                CFG_IDX_SUBSYS:
                                    next_s.ssid = LREQ.wdata;
                                CFG_IDX_INTLINE:
                                    next_s.int_line = LREQ.wdata[7:0];
                                default: ;
                            endcase
                        end
                    end
                endcase
            end
            else
            begin
                case (LREQ.addr)
                    OFS_IND_ADDR:  next_s.l_rdata = s.np_addr;
                    OFS_IND_CBE:   next_s.l_rdata = s.np_cbe;
                    OFS_IND_WDATA: next_s.l_rdata = s.np_wdata;
                    OFS_IND_RDATA: next_s.l_rdata = s.np_rdata;
                    OFS_CTRL:
                    begin
                        next_s.l_rdata = 32'h00000000;
                        next_s.l_rdata[CSR_HOST_BIT] = s.host_mode;
                        next_s.l_rdata[CSR_ARB_BIT] = s.arb_en;
                        next_s.l_rdata[CSR_IC_BIT] = s.ic;
                        next_s.l_rdata[CSR_BUSY_RD_BIT] = s.busy_rd;
                        next_s.l_rdata[CSR_BUSY_WR_BIT] = s.busy_wr;
                    end
                    default:
                        next_s.l_rdata = (cfg_hit_local && !s.ic)
                                       ? cfg_read(LREQ.addr[7:2], s)
                                       : 32'h00000000;
                endcase
            end
        end

        if (pe)
        begin
            case (s.st)
                ST_IDLE:
                begin
                    if (!s.s2.frame_n)
                    begin
                        if (s.s2.idsel && !s.ic)
                        begin
                            next_s.st = ST_T_STOP;
                            next_s.po.devsel_n = 1'b0;
                            next_s.po.devsel_oe = 1'b1;
                            next_s.po.stop_n = 1'b0;
                            next_s.po.stop_oe = 1'b1;
                            next_s.po.trdy_oe = 1'b1;
                        end
                        else if (cfg_claim)
                        begin
                            next_s.st = ST_T_DATA;
                            next_s.t_idx = s.s2.ad[7:2];
                            next_s.t_write = s.s2.cbe_n[0];
                            next_s.po.devsel_n = 1'b0;
                            next_s.po.devsel_oe = 1'b1;
                            next_s.po.trdy_n = 1'b0;
                            next_s.po.trdy_oe = 1'b1;
                            next_s.po.stop_oe = 1'b1;
                            // Whole word regardless of enables
                            next_s.po.ad = cfg_read(s.s2.ad[7:2], s);
                            next_s.po.ad_oe = ~s.s2.cbe_n[0];
                        end
                        else
                            next_s.st = ST_T_WAIT;
                    end
                    else if ((s.busy_rd || s.busy_wr) && s.s2.irdy_n)
                    begin
                        next_s.st = ST_M_ADDR;
                        next_s.po.frame_n = 1'b0;
                        next_s.po.frame_oe = 1'b1;
                        next_s.po.irdy_oe = 1'b1;
                        next_s.po.ad = s.np_addr;
                        next_s.po.ad_oe = 1'b1;
                        next_s.po.cbe_n = s.np_cbe[CBE_CMD_LSB +: 4];
                        next_s.po.cbe_oe = 1'b1;
                    end
                end
                ST_T_WAIT:
                    if (s.s2.frame_n && s.s2.irdy_n)
                        next_s.st = ST_IDLE;
                ST_T_DATA:
                begin
                    if (!s.s2.irdy_n)
                    begin
                        if (s.t_write)
                        begin
                            case (s.t_idx)
                                CFG_IDX_CMD:
                                    next_s.cfg_cmd = t_merged[15:0];
                                CFG_IDX_BAR0:
                                    next_s.bar0 = t_merged & BAR0_MASK;
                                CFG_IDX_INTLINE:
                                    next_s.int_line = t_merged[7:0];
                                default: ;
                            endcase
                        end
                        next_s.po.trdy_n = 1'b1;
                        next_s.po.ad_oe = 1'b0;
                        if (!s.s2.frame_n)
                        begin
                            next_s.st = ST_T_STOP;
                            next_s.po.stop_n = 1'b0;
                        end
                        else
                            next_s.st = ST_T_TURN;
                    end
                end
                ST_T_STOP:
                    if (s.s2.frame_n)
                    begin
                        next_s.st = ST_T_TURN;
                        next_s.po.devsel_n = 1'b1;
                        next_s.po.stop_n = 1'b1;
                    end
                ST_T_TURN:
                begin
                    next_s.st = ST_IDLE;
                    next_s.po = PIN_OUT_IDLE;
                end
                ST_M_ADDR:
                begin
                    next_s.st = ST_M_DATA;
                    next_s.abort_cnt = 3'h0;
                    next_s.po.frame_n = 1'b1;
                    next_s.po.irdy_n = 1'b0;
                    next_s.po.cbe_n = s.np_cbe[CBE_BE_LSB +: 4];
                    next_s.po.ad = s.np_wdata;
                    next_s.po.ad_oe = s.is_write;
                end
                ST_M_DATA:
                begin
                    next_s.abort_cnt = s.abort_cnt + 3'h1;
                    if (!s.s2.trdy_n || !s.s2.stop_n
                        || (s.s2.devsel_n && s.abort_cnt == ABORT_EDGES))
                    begin
                        next_s.st = ST_M_TURN;
                        next_s.po.irdy_n = 1'b1;
                        next_s.po.ad_oe = 1'b0;
                        next_s.po.cbe_oe = 1'b0;
                        // Retry without data repeats the cycle
                        next_s.m_ok = !s.s2.trdy_n || s.s2.stop_n;
                        if (!s.is_write)
                            next_s.np_rdata = !s.s2.trdy_n
                                            ? s.s2.ad : ABORT_DATA;
                    end
                end
                ST_M_TURN:
                begin
                    next_s.st = ST_IDLE;
                    next_s.po = PIN_OUT_IDLE;
                    if (s.m_ok)
                    begin
                        next_s.busy_rd = 1'b0;
                        next_s.busy_wr = 1'b0;
                    end
                end
                default:
                begin
                    next_s.st = ST_IDLE;
                    next_s.po = PIN_OUT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s <= '0;
            s.st <= ST_IDLE;
            s.po <= PIN_OUT_IDLE;
            s.s1 <= PIN_IN_IDLE;
            s.s2 <= PIN_IN_IDLE;
            s.clk_q <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign PCI_OUT = s.po;
    assign LRDATA = s.l_rdata;
    assign LACK = s.l_ack;
    assign HOST_MODE = s.host_mode;
    assign ARB_EN = s.arb_en;
    assign INIT_COMPLETE = s.ic;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_addr_phase;
        pe && s.st == ST_IDLE && !s.s2.frame_n;
    endsequence

    sequence s_ind_write(logic [9:0] ofs);
        lreq_take && LREQ.we && LREQ.addr == ofs;
    endsequence

    property p_read_start;
        s_ind_write(OFS_IND_CBE) ##0 !LREQ.wdata[0]
            |=> s.busy_rd && !s.is_write;
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("read command write did not start a read");

    property p_write_start;
        s_ind_write(OFS_IND_WDATA) |=> s.busy_wr && s.is_write;
    endproperty
    a_write_start: assert property (p_write_start)
        else $error("write data write did not start a write");

    property p_addr_asis;
        s.st == ST_M_ADDR |-> PCI_OUT.ad == s.np_addr && !PCI_OUT.frame_n
            && PCI_OUT.cbe_n == s.np_cbe[3:0];
    endproperty
    a_addr_asis: assert property (p_addr_asis)
        else $error("address phase not driven from indirect registers");

    property p_rd_retry;
        LREQ.req && !LREQ.we && s.busy_rd |-> LRETRY ##1 !LACK;
    endproperty
    a_rd_retry: assert property (p_rd_retry)
        else $error("local read not retried during indirect read");

    property p_wr_retry;
        LREQ.req && LREQ.we && s.busy_wr |-> LRETRY ##1 $stable(s.np_wdata);
    endproperty
    a_wr_retry: assert property (p_wr_retry)
        else $error("local write not retried during indirect write");

    property p_no_ic_retry;
        s_addr_phase ##0 s.s2.idsel && !s.ic
            |=> s.st == ST_T_STOP && !PCI_OUT.stop_n && PCI_OUT.trdy_n;
    endproperty
    a_no_ic_retry: assert property (p_no_ic_retry)
        else $error("cycle before init complete was not retried");

    property p_claim;
        s_addr_phase ##0 cfg_claim
            |=> !PCI_OUT.devsel_n && !PCI_OUT.trdy_n && s.st == ST_T_DATA;
    endproperty
    a_claim: assert property (p_claim)
        else $error("configuration access not claimed");

    property p_burst_stop;
        pe && s.st == ST_T_DATA && !s.s2.irdy_n && !s.s2.frame_n
            |=> !PCI_OUT.stop_n && PCI_OUT.trdy_n;
    endproperty
    a_burst_stop: assert property (p_burst_stop)
        else $error("burst not disconnected after one word");

    property p_unimpl_zero;
        s_addr_phase ##0 cfg_claim && s.s2.ad[7:2] == 6'h20
            |=> PCI_OUT.ad == 32'h00000000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented register read not zero");

    property p_ssid_ro;
        $changed(s.ssid) |-> $past(lreq_take && LREQ.we && !s.ic);
    endproperty
    a_ssid_ro: assert property (p_ssid_ro)
        else $error("subsystem register changed from the bus");

    property p_ic_set;
        $rose(s.ic) |-> $past(lreq_take && LREQ.we && LREQ.addr == OFS_CTRL);
    endproperty
    a_ic_set: assert property (p_ic_set)
        else $error("init complete rose without a software write");

    property p_rdata_cap;
        pe && s.st == ST_M_DATA && !s.s2.trdy_n && !s.is_write
            |=> s.np_rdata == $past(s.s2.ad) ##1 s.st == ST_M_TURN;
    endproperty
    a_rdata_cap: assert property (p_rdata_cap)
        else $error("read word not captured");
endmodule : cau_config_access_unit
`default_nettype wire

// >>> cau_pci_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cau_pci_partner (
    input  wire cau_pkg::cau_pin_out_t d,
    output wire cau_pkg::cau_pin_in_t  pin
);
    import cau_pkg::*;
    logic        pclk = 1'h0;
    logic        fr = 1'h1;
    logic        ir = 1'h1;
    logic        tr = 1'h1;
    logic        dv = 1'h1;
    logic        sp = 1'h1;
    logic        ids = 1'h0;
    logic        burst = 1'h0;
    logic        disc = 1'h0;
    logic [3:0]  cb = 4'hF;
    logic [3:0]  t_cmd;
    logic [3:0]  t_be;
    logic [31:0] ad = 32'h0;
    logic [31:0] rdata = 32'h0;
    logic [31:0] t_addr;
    logic [31:0] t_data;
    int          retries = 0;
    int          waits = 0;

    // Bus clock runs free, as a backplane clock does
    always #40 pclk = ~pclk;

    // Control lines idle high through pull-ups
    assign pin = '{clk: pclk, frame_n: d.frame_oe ? d.frame_n : fr,
        irdy_n: d.irdy_oe ? d.irdy_n : ir, trdy_n: d.trdy_oe ? d.trdy_n : tr,
        devsel_n: d.devsel_oe ? d.devsel_n : dv,
        stop_n: d.stop_oe ? d.stop_n : sp, idsel: ids,
        ad: d.ad_oe ? d.ad : ad, cbe_n: d.cbe_oe ? d.cbe_n : cb};

    // Target for the indirect cycles; may insert waits or as many retries as retries holds
    always @(posedge pclk)
    begin
        if (d.frame_oe && !d.frame_n)
        begin
            t_addr = pin.ad;
            t_cmd = pin.cbe_n;
            repeat (waits) @(negedge pclk);
            @(negedge pclk);
            dv <= 1'h0;
            if (retries > 0) sp <= 1'h0;
            else tr <= 1'h0;
            if (!t_cmd[0]) ad <= rdata;
            @(posedge pclk);
            while (pin.irdy_n) @(posedge pclk);
            t_be = pin.cbe_n;
            t_data = pin.ad;
            if (retries > 0) retries--;
            @(negedge pclk);
            {dv, tr, sp} <= 3'h7;
            // A released bus must not keep showing the old word
            ad <= ~ad;
        end
    end

    // Initiator: one single-word configuration cycle
    task automatic cfg(input logic sel, input logic [31:0] a,
        input logic [3:0] cmd, input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] rd, output logic [1:0] code);
        @(negedge pclk);
        fr <= 1'h0;
        ids <= sel;
        ad <= a;
        cb <= cmd;
        @(negedge pclk);
        fr <= !burst;
        ir <= 1'h0;
        ids <= 1'h0;
        cb <= be;
        ad <= cmd[0] ? wd : ~a;
        code = 2'h2;
        rd = 32'h0;
        for (int i = 0; i < 6 && code == 2'h2; i++)
        begin
            @(posedge pclk);
            if (!pin.trdy_n) {rd, code} = {pin.ad, 2'h0};
            else if (!pin.stop_n) code = 2'h1;
        end
        @(negedge pclk);
        disc = !pin.stop_n;
        ir <= 1'h1;
        fr <= 1'h1;
        cb <= 4'hF;
        ad <= ~ad;
    endtask : cfg
endmodule : cau_pci_partner
`default_nettype wire

// >>> cau_config_access_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cau_config_access_unit_tb_top;
    import cau_pkg::*;
    typedef struct packed {
        logic        we;
        logic [9:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } cau_lrow_t;
    typedef struct packed {
        logic        sel;
        logic [31:0] a;
        logic [7:0]  cbe;
        logic [31:0] d;
        logic [1:0]  code;
        logic [31:0] e;
    } cau_brow_t;
    // Arbitrary identity values
    localparam logic [31:0] IDW = 32'h00C35A17;
    localparam cau_lrow_t LR [8] = '{'{1'h1, 10'h010, 32'h3, 32'h0},
        '{1'h0, 10'h010, 32'h0, 32'h3}, '{1'h1, 10'h010, 32'h2, 32'h0},
        '{1'h0, 10'h010, 32'h0, 32'h2}, '{1'h1, 10'h12C, 32'h5A5A1234, 32'h0},
        '{1'h0, 10'h12C, 32'h0, 32'h5A5A1234}, '{1'h0, 10'h100, 32'h0, IDW},
        '{1'h0, 10'h020, 32'h0, 32'h0}};
    localparam cau_brow_t BR [16] = '{'{1'h1, 32'h0, 8'hFA, 32'h0, 2'h0, IDW},
        '{1'h1, 32'h2C, 8'h0B, 32'h0, 2'h0, 32'h0},
        '{1'h1, 32'h2C, 8'h0A, 32'h0, 2'h0, 32'h5A5A1234},
        '{1'h1, 32'h10, 8'h7B, 32'hA1A2A3A4, 2'h0, 32'h0},
        '{1'h1, 32'h10, 8'h8B, 32'h5B5B5B5B, 2'h0, 32'h0},
        '{1'h1, 32'h10, 8'h0A, 32'h0, 2'h0, 32'hA1000000},
        '{1'h1, 32'h80, 8'h0B, 32'hFFFFFFFF, 2'h0, 32'h0},
        '{1'h1, 32'h80, 8'h0A, 32'h0, 2'h0, 32'h0},
        '{1'h1, 32'h4, 8'hCB, 32'hFFFFA5C3, 2'h0, 32'h0},
        '{1'h1, 32'h4, 8'h0A, 32'h0, 2'h0, 32'h0000A5C3},
        '{1'h1, 32'h3C, 8'hEB, 32'h1234567F, 2'h0, 32'h0},
        '{1'h1, 32'h3C, 8'h0A, 32'h0, 2'h0, 32'h7F},
        '{1'h1, 32'h1, 8'h0A, 32'h0, 2'h2, 32'h0},
        '{1'h1, 32'h100, 8'h0A, 32'h0, 2'h2, 32'h0},
        '{1'h0, 32'h0, 8'h0A, 32'h0, 2'h2, 32'h0},
        '{1'h1, 32'h0, 8'h06, 32'h0, 2'h2, 32'h0}};
    logic         mclk = 1'h0;
    logic         reset_n = 1'h0;
    cau_lreq_t    lreq = '0;
    wire          cau_pin_in_t pin;
    wire          cau_pin_out_t po;
    logic [31:0]  lrdata;
    logic [31:0]  rd;
    logic         lack, lretry, host_mode, arb_en, init_complete, rt;
    logic [1:0]   code;
    int           bad_count = 0;
    int           comparisons = 0;

    cau_config_access_unit #(.VENDOR_ID(IDW[15:0]), .DEVICE_ID(IDW[31:16]))
    cau_config_access_unit_inst (.MCLK(mclk), .RESET_N(reset_n),
        .PCI_IN(pin), .PCI_OUT(po), .LREQ(lreq), .LRDATA(lrdata),
        .LACK(lack), .LRETRY(lretry), .HOST_MODE(host_mode),
        .ARB_EN(arb_en), .INIT_COMPLETE(init_complete));
    cau_pci_partner cau_pci_partner_inst (.d(po), .pin(pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until taken; a refusal is reported through rt
    task automatic acc(input logic we, input logic [9:0] a,
        input logic [31:0] d, output logic [31:0] rdv, output logic rtv);
        @(negedge mclk);
        lreq = '{req: 1'h1, we: we, addr: a, wdata: d};
        #1;
        rtv = lretry;
        while (lretry !== 1'h0) @(negedge mclk);
        @(negedge mclk);
        rdv = lrdata;
        chk({31'h0, lack}, 32'h1);
        lreq.req = 1'h0;
    endtask : acc

    task automatic results();
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    initial
    begin
        #300000;
        bad_count++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'h1;
        chk({host_mode, arb_en, init_complete, lack}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            acc(LR[i].we, LR[i].a, LR[i].d, rd, rt);
            if (!LR[i].we) chk(rd, LR[i].e);
        end
        cau_pci_partner_inst.cfg(1'h1, 32'h0, 4'hA, 4'h0, 32'h0,
            rd, code);
        chk({30'h0, code}, 32'h1);
        cau_pci_partner_inst.retries = 1;
        acc(1'h1, OFS_IND_ADDR, 32'h00010010, rd, rt);
        acc(1'h1, OFS_IND_CBE, 32'h0000000B, rd, rt);
        acc(1'h1, OFS_IND_WDATA, 32'hFFFFFFFF, rd, rt);
        acc(1'h1, OFS_IND_ADDR, 32'h00010010, rd, rt);
        chk({31'h0, rt}, 32'h1);
        chk(cau_pci_partner_inst.t_addr, 32'h00010010);
        chk(cau_pci_partner_inst.t_data, 32'hFFFFFFFF);
        chk({24'h0, cau_pci_partner_inst.t_be, cau_pci_partner_inst.t_cmd},
            32'h0000000B);
        cau_pci_partner_inst.rdata = 32'hFC000008;
        cau_pci_partner_inst.waits = 2;
        acc(1'h1, OFS_IND_CBE, 32'h0000000A, rd, rt);
        acc(1'h0, OFS_CTRL, 32'h0, rd, rt);
        chk({31'h0, rt}, 32'h1);
        acc(1'h0, OFS_IND_RDATA, 32'h0, rd, rt);
        chk(rd, 32'hFC000008);
        chk({28'h0, cau_pci_partner_inst.t_cmd}, 32'hA);
        acc(1'h1, OFS_CTRL, 32'h8001, rd, rt);
        chk({29'h0, host_mode, arb_en, init_complete}, 32'h5);
        acc(1'h0, 10'h12C, 32'h0, rd, rt);
        chk(rd, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            cau_pci_partner_inst.cfg(BR[i].sel, BR[i].a, BR[i].cbe[3:0],
                BR[i].cbe[7:4], BR[i].d, rd, code);
            chk({30'h0, code}, {30'h0, BR[i].code});
            if (!BR[i].cbe[0]) chk(rd, BR[i].e);
        end
        // Frame held into the data phase; last, as the disconnect adds a clock
        cau_pci_partner_inst.burst = 1'h1;
        cau_pci_partner_inst.cfg(1'h1, 32'h0, 4'hA, 4'h0, 32'h0,
            rd, code);
        chk(rd, IDW);
        chk({31'h0, cau_pci_partner_inst.disc}, 32'h1);
        results();
    end
endmodule : cau_config_access_unit_tb_top
`default_nettype wire
